// file: ssp_spi_core.sv
// ssp_spi_core: spi mode of the synchronous serial port, master and slave
// assumes: one system clock; external pins arrive unsynchronised;
// software side reaches control bits through plain write and read strobes
`default_nettype none

// ---------------------------------------------------------------
// module
// ---------------------------------------------------------------
// How it works
// - eight-bit shift, msb out, lsb in
// - output on chosen edge, sample opposite
// - eight clocks exchange whole register
// - full byte copies to buffer, flags set
// - buffer write loads buffer and shifter
// - master starts on buffer write
// - write during transfer dropped, collision set
// - buffer read clears full flag
// - receive side is double buffered
// - runs only while enable bit set
// - enable hands four pins to port
// - wrong direction bit overrides sck and sdo function only
// - control and status bits select options
// - master drives clock, slave receives it
// - mode codes pick master or slave
// - status low read-only, control fully writable
// - shifter only reachable through buffer
// - baud register reloads rate generator
// - five master clock rate choices
// - unselected slave ignores bus, sends nothing
// - select high floats output mid-byte
module ssp_spi_core
   import ssp_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rstn,
   input wire logic clkEn,
   // software write side
   input wire logic ctlaWr,
   input wire logic statWr,
   input wire logic baudWr,
   input wire logic bufWr,
   input wire logic [7:0] wrData,
   input wire logic bufRd,
   // timer period output pulse (same clock domain)
   input wire logic tmrTick,
   // pin direction bits (1 = input) for sdi, sdo, sck, ss
   input wire logic dirSdi,
   input wire logic dirSdo,
   input wire logic dirSck,
   input wire logic dirSs,
   // spi pins
   input wire logic sckIn,
   output logic sckOut,
   output logic sckOen,
   input wire logic sdiIn,
   output logic sdoOut,
   output logic sdoOen,
   input wire logic ssInN,
   // software read side
   output logic [7:0] ctlaRead,
   output logic [7:0] statRead,
   output logic [7:0] baudRead,
   output logic [7:0] bufRead,
   output logic irqFlag,
   // pin ownership
   output logic pinsOwned
);
   import ssp_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] ctla_ff;
   logic [1:0] statCfg_ff;
   logic [7:0] baud_ff;
   logic [7:0] buf_ff;
   logic [7:0] shift_ff;
   logic bufFull_ff;
   logic irq_ff;
   logic [3:0] bitCnt_ff;
   logic [7:0] rateCnt_ff;
   logic sckInt_ff;
   logic sdoBit_ff;
   logic sampled_ff;
   ssp_state_t state_ff;
   logic [2:0] sckSync_ff;
   logic [2:0] sdiSync_ff;
   logic [2:0] ssSync_ff;
   logic sckStable_ff;
   logic ssStable_ff;

   // ------------------------------------------------------------
   // decoding
   // ------------------------------------------------------------
   // master for 00xx and 1010, slave for 010x
   function automatic logic isMaster(input logic [3:0] m);
      isMaster = (m[3:2] == 2'b00) || (m == MODE_BAUD);
   endfunction

   function automatic logic isSlave(input logic [3:0] m);
      isSlave = (m[3:1] == MODE_SLV_SS[3:1]);
   endfunction

   logic [3:0] mode;
   logic enable;
   logic ckp;
   logic cke;
   logic smp;
   logic master;
   logic slave;
   logic ssUsed;
   logic busy;
   logic sdiVal;
   logic ssHigh;
   assign mode = ctla_ff[CTLA_MODE_HI:CTLA_MODE_LO];
   assign enable = ctla_ff[CTLA_EN];
   assign ckp = ctla_ff[CTLA_CKP];
   assign cke = statCfg_ff[1];
   assign smp = statCfg_ff[0];
   assign master = enable && isMaster(mode);
   assign slave = enable && isSlave(mode);
   assign ssUsed = slave && (mode == MODE_SLV_SS);
   assign busy = (bitCnt_ff != CNT_ZERO) || (state_ff != ST_IDLE);
   assign sdiVal = sdiSync_ff[2];
   assign ssHigh = ssStable_ff;

   // ------------------------------------------------------------
   // pin synchronisers: a change counts once stages two and three agree
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sckSync_ff <= SYNC3_ZERO;
         sdiSync_ff <= SYNC3_ZERO;
         ssSync_ff <= 3'b111;
         sckStable_ff <= 1'b0;
         ssStable_ff <= 1'b1;
      end
      else if (clkEn)
      begin
         sckSync_ff <= {sckSync_ff[1:0], sckIn};
         sdiSync_ff <= {sdiSync_ff[1:0], sdiIn};
         ssSync_ff <= {ssSync_ff[1:0], ssInN};
         if (sckSync_ff[1] == sckSync_ff[2])
            sckStable_ff <= sckSync_ff[2];
         if (ssSync_ff[1] == ssSync_ff[2])
            ssStable_ff <= ssSync_ff[2];
      end
   end

   // ------------------------------------------------------------
   // master rate generator
   // ------------------------------------------------------------
   // reload is a half period; tmr option toggles once per timer tick
   logic [7:0] halfReload;
   always_comb
   begin
      case (mode)
         MODE_DIV4: halfReload = HALF_DIV4;
         MODE_DIV16: halfReload = HALF_DIV16;
         MODE_DIV64: halfReload = HALF_DIV64;
         // fosc/(4*(n+1)) gives half period 2*(n+1) clocks
         MODE_BAUD: halfReload = 8'({baud_ff[6:0], 1'b1});
         default: halfReload = HALF_DIV4;
      endcase
   end

   logic halfTick;
   assign halfTick = (mode == MODE_TMR) ? tmrTick
      : (rateCnt_ff == BYTE_ZERO);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rateCnt_ff <= BYTE_ZERO;
      else if (clkEn)
      begin
         if (!master || state_ff == ST_IDLE || halfTick)
            rateCnt_ff <= halfReload;
         else
            rateCnt_ff <= rateCnt_ff - 8'h01;
      end
   end

   // ------------------------------------------------------------
   // edge events in both modes
   // ------------------------------------------------------------
   // lead = first edge of a bit cell (idle->active), trail = the other
   logic sckPrev_ff;
   logic slvLead;
   logic slvTrail;
   logic mstLead;
   logic mstTrail;
   logic leadEv;
   logic trailEv;
   logic writeOk;
   logic doneBit;
   assign slvLead = slave && !(ssUsed && ssHigh)
      && (sckPrev_ff == ckp) && (sckStable_ff != ckp);
   assign slvTrail = slave && !(ssUsed && ssHigh)
      && (sckPrev_ff != ckp) && (sckStable_ff == ckp);
   assign mstLead = master && state_ff == ST_LEAD && halfTick;
   assign mstTrail = master && state_ff == ST_TRAIL && halfTick;
   assign leadEv = mstLead || slvLead;
   assign trailEv = mstTrail || slvTrail;
   assign writeOk = bufWr && enable && !busy && !ctla_ff[CTLA_WRITE_COLLISION_BIT];

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         sckPrev_ff <= 1'b0;
      else if (clkEn)
         sckPrev_ff <= sckStable_ff;
   end

   // cke=1: data changes on trail (back to idle), sampled on lead
   // cke=0: data changes on lead, sampled on trail
   logic shiftEv;
   logic sampEv;
   assign shiftEv = cke ? trailEv : leadEv;
   assign sampEv = cke ? leadEv : trailEv;

   // master cell counter: the frame ends after eight clock pulses
   logic [3:0] cellCnt_ff;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cellCnt_ff <= CNT_ZERO;
      else if (clkEn)
      begin
         if (writeOk)
            cellCnt_ff <= CNT_ZERO;
         else if (mstTrail)
            cellCnt_ff <= cellCnt_ff + 4'h1;
      end
   end

   // sdi lags the sck we launch by the synchroniser depth, so a master
   // sample waits three clocks; smp waits one more (fixed, not a half cell)
   logic [3:0] sampPipe_ff;
   logic mstSamp;
   logic mstPending;
   assign mstSamp = smp ? sampPipe_ff[3] : sampPipe_ff[2];
   assign mstPending = smp ? (|sampPipe_ff) : (|sampPipe_ff[2:0]);
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         sampPipe_ff <= CNT_ZERO;
      else if (clkEn)
         sampPipe_ff <= master ? {sampPipe_ff[2:0], sampEv} : CNT_ZERO;
   end

   // ------------------------------------------------------------
   // master clock state machine
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= ST_IDLE;
         sckInt_ff <= 1'b0;
      end
      else if (clkEn)
      begin
         if (!master)
         begin
            state_ff <= ST_IDLE;
            sckInt_ff <= ckp;
         end
         else
         begin
            case (state_ff)
               ST_IDLE:
               begin
                  sckInt_ff <= ckp;
                  if (writeOk)
                     state_ff <= ST_LEAD;
               end
               ST_LEAD:
                  if (halfTick)
                  begin
                     sckInt_ff <= !ckp;
                     state_ff <= ST_TRAIL;
                  end
               ST_TRAIL:
                  if (halfTick)
                  begin
                     sckInt_ff <= ckp;
                     state_ff <= (cellCnt_ff == BITS_PER_BYTE - 4'h1)
                        ? ST_IDLE : ST_LEAD;
                  end
               default: state_ff <= ST_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // shift register and bit counter
   // ------------------------------------------------------------
   // master samples come late from the pipe, slave ones at once
   logic sampNow;
   logic byteDone;
   assign sampNow = master ? mstSamp : sampEv;
   // byte complete once eighth bit taken and no sample is pending
   assign byteDone = (bitCnt_ff == BITS_PER_BYTE) && !sampNow
      && (!master || state_ff == ST_IDLE);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         shift_ff <= BYTE_ZERO;
         bitCnt_ff <= CNT_ZERO;
         sdoBit_ff <= 1'b0;
         sampled_ff <= 1'b0;
      end
      else if (clkEn)
      begin
         if (!enable || (ssUsed && ssHigh))
            bitCnt_ff <= CNT_ZERO;
         else
         begin
            if (sampNow)
            begin
               shift_ff <= {shift_ff[6:0], sdiVal};
               bitCnt_ff <= (bitCnt_ff == BITS_PER_BYTE)
                  ? CNT_ZERO + 4'h1 : bitCnt_ff + 4'h1;
               sampled_ff <= 1'b1;
            end
            // a pending master sample has not shifted yet: take bit six
            if (shiftEv && master)
               sdoBit_ff <= mstPending ? shift_ff[6] : shift_ff[7];
            else if (shiftEv && sampled_ff)
            begin
               sdoBit_ff <= shift_ff[7];
               sampled_ff <= 1'b0;
            end
            if (byteDone)
               bitCnt_ff <= CNT_ZERO;
         end
         // a deselected slave still takes its next byte
         if (writeOk)
         begin
            shift_ff <= wrData;
            sdoBit_ff <= wrData[7];
            sampled_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // buffer, flags and software registers
   // ------------------------------------------------------------
   // hardware set beats software clear on the same cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         buf_ff <= BYTE_ZERO;
         bufFull_ff <= 1'b0;
         irq_ff <= 1'b0;
         ctla_ff <= CTLA_RST;
         statCfg_ff <= CTLS_RST[1:0];
         baud_ff <= BAUD_RST;
      end
      else if (clkEn)
      begin
         if (ctlaWr)
            ctla_ff <= wrData;
         if (statWr)
            statCfg_ff <= {wrData[STAT_SMP], wrData[STAT_CKE]};
         if (baudWr)
            baud_ff <= wrData;
         if (writeOk)
            buf_ff <= wrData;
         if (bufRd)
            bufFull_ff <= 1'b0;
         if (bufWr && enable && busy)
            ctla_ff[CTLA_WRITE_COLLISION_BIT] <= 1'b1;
         if (byteDone && enable)
         begin
            if (bufFull_ff && !bufRd)
               ctla_ff[CTLA_OV] <= 1'b1;
            buf_ff <= shift_ff;
            bufFull_ff <= 1'b1;
            irq_ff <= 1'b1;
         end
         else if (bufRd)
            irq_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // pin drive and readback, all registered
   // ------------------------------------------------------------
   // output enable active low; direction bit 1 means input
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sckOut <= 1'b0;
         sckOen <= 1'b1;
         sdoOut <= 1'b0;
         sdoOen <= 1'b1;
         pinsOwned <= 1'b0;
         ctlaRead <= CTLA_RST;
         statRead <= BYTE_ZERO;
         baudRead <= BAUD_RST;
         bufRead <= BYTE_ZERO;
         irqFlag <= 1'b0;
      end
      else if (clkEn)
      begin
         pinsOwned <= enable;
         sckOut <= sckInt_ff;
         sckOen <= !(master && !dirSck);
         sdoOut <= sdoBit_ff;
         sdoOen <= !(enable && !dirSdo
            && !(ssUsed && ssHigh));
         ctlaRead <= ctla_ff;
         statRead <= {statCfg_ff, 5'b00000, bufFull_ff};
         baudRead <= baud_ff;
         bufRead <= buf_ff;
         irqFlag <= irq_ff;
      end
   end

   // sdi and ss direction bits are not used; those pins act whatever their setting
   logic unusedDir;
   assign unusedDir = dirSdi & dirSs;

endmodule // ssp_spi_core
`default_nettype wire

// file: ssp_pkg.sv
// ssp_pkg: constants, field positions and mode codes of the spi port core
// assumes: used by ssp_spi_core, its checker and its bench; 125 MHz system clock
`default_nettype none
package ssp_pkg;
   // control register a field positions
   localparam int CTLA_MODE_LO = 0;
   localparam int CTLA_MODE_HI = 3;
   localparam int CTLA_CKP = 4;
   localparam int CTLA_EN = 5;
   localparam int CTLA_OV = 6;
   localparam int CTLA_WRITE_COLLISION_BIT = 7;
   // status register field positions
   localparam int STAT_BF = 0;
   localparam int STAT_CKE = 6;
   localparam int STAT_SMP = 7;
   // reset values
   localparam logic [7:0] CTLA_RST = 8'h00;
   localparam logic [7:0] CTLS_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // bit counter
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   // mode codes
   localparam logic [3:0] MODE_DIV4 = 4'h0;
   localparam logic [3:0] MODE_DIV16 = 4'h1;
   localparam logic [3:0] MODE_DIV64 = 4'h2;
   localparam logic [3:0] MODE_TMR = 4'h3;
   localparam logic [3:0] MODE_SLV_SS = 4'h4;
   localparam logic [3:0] MODE_SLV = 4'h5;
   localparam logic [3:0] MODE_BAUD = 4'ha;
   // half period reload counts in system clocks (half of divide, minus one)
   localparam logic [7:0] HALF_DIV4 = 8'h01;
   localparam logic [7:0] HALF_DIV16 = 8'h07;
   localparam logic [7:0] HALF_DIV64 = 8'h1f;
   localparam logic [1:0] SYNC_ZERO = 2'b00;
   localparam logic [2:0] SYNC3_ZERO = 3'b000;
   typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} ssp_state_t;
endpackage : ssp_pkg
`default_nettype wire

// file: ssp_spi_core_asserts.sv
// ssp_spi_core_asserts: port-level checks of the spi port core
// assumes: bound to ssp_spi_core; one clock, rstn async active low
`default_nettype none
module ssp_spi_core_asserts
   import ssp_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rstn,
   input wire logic clkEn,
   // software side
   input wire logic ctlaWr,
   input wire logic statWr,
   input wire logic bufWr,
   input wire logic bufRd,
   input wire logic [7:0] wrData,
   input wire logic dirSdo,
   // pins
   input wire logic ssInN,
   input wire logic sckOut,
   input wire logic sckOen,
   input wire logic sdoOen,
   // read side
   input wire logic [7:0] ctlaRead,
   input wire logic [7:0] statRead,
   input wire logic irqFlag,
   input wire logic pinsOwned
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // mirrors run one cycle behind the register itself
   property p_enOwn;
      ctlaWr && clkEn |-> ##2 pinsOwned == $past(wrData[5], 2);
   endproperty
   a_enOwn: assert property (p_enOwn)
      else $error("enable not mirrored on pins");
   property p_ctlMirror;
      ctlaWr && clkEn |-> ##2 ctlaRead[5:0] == $past(wrData[5:0], 2);
   endproperty
   a_ctlMirror: assert property (p_ctlMirror)
      else $error("control read back wrong");
   property p_statMirror;
      statWr && clkEn |-> ##2 statRead[7:6] == $past(wrData[7:6], 2);
   endproperty
   a_statMirror: assert property (p_statMirror)
      else $error("status upper bits read back wrong");
   property p_statRo;
      statRead[5:1] == 5'h00;
   endproperty
   a_statRo: assert property (p_statRo)
      else $error("status reserved bits set");
   property p_rdClr;
      bufRd && clkEn |-> ##2 !irqFlag && !statRead[STAT_BF];
   endproperty
   a_rdClr: assert property (p_rdClr)
      else $error("buffer read left flags set");
   property p_irqFull;
      $rose(irqFlag) |=> statRead[STAT_BF];
   endproperty
   a_irqFull: assert property (p_irqFull)
      else $error("flag without full bit");
   // two quiet cycles: enable to pin hand-over takes one register stage
   property p_offPins;
      !pinsOwned ##1 !pinsOwned |-> sckOen && sdoOen;
   endproperty
   a_offPins: assert property (p_offPins)
      else $error("disabled port drives a pin");
   property p_dirOvr;
      dirSdo [*3] |-> sdoOen;
   endproperty
   a_dirOvr: assert property (p_dirOvr)
      else $error("direction bit did not override");
   property p_clkStart;
      bufWr && clkEn && pinsOwned && ctlaRead[3:0] == MODE_DIV4
         && !ctlaRead[4] && !ctlaRead[7] |-> ##[1:8] sckOut;
   endproperty
   a_clkStart: assert property (p_clkStart)
      else $error("master clock did not start");
   property p_write_collision_bit;
      (bufWr && pinsOwned && ctlaRead[3:0] == MODE_DIV4) ##[1:3] bufWr
         |-> ##2 ctlaRead[CTLA_WRITE_COLLISION_BIT];
   endproperty
   a_write_collision_bit: assert property (p_write_collision_bit)
      else $error("collision not flagged");
   property p_ssFloat;
      (ctlaRead[3:0] == MODE_SLV_SS && ssInN) [*6] |-> sdoOen;
   endproperty
   a_ssFloat: assert property (p_ssFloat)
      else $error("deselected slave drives data");
   c_irq: cover property ($rose(irqFlag));
   c_write_collision_bit: cover property ($rose(ctlaRead[CTLA_WRITE_COLLISION_BIT]));
   c_slv: cover property (ctlaRead[3:0] == MODE_SLV && irqFlag);
endmodule // ssp_spi_core_asserts
bind ssp_spi_core ssp_spi_core_asserts u_chk (
   .clk(clk), .rstn(rstn), .clkEn(clkEn), .ctlaWr(ctlaWr),
   .statWr(statWr), .bufWr(bufWr), .bufRd(bufRd), .wrData(wrData),
   .dirSdo(dirSdo), .ssInN(ssInN), .sckOut(sckOut), .sckOen(sckOen),
   .sdoOen(sdoOen), .ctlaRead(ctlaRead), .statRead(statRead),
   .irqFlag(irqFlag), .pinsOwned(pinsOwned)
);
`default_nettype wire

// file: ssp_slave_model.sv
// ssp_slave_model: far-side spi slave used while the core is master
// assumes: idle-low clock, data out on rising edge, sampled on falling
`default_nettype none
module ssp_slave_model
(
   // spi bus
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   // test side
   input wire logic [7:0] txByte,
   output logic [7:0] rxByte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] outSr = 8'h00;
   int nBits = 0;
   // ---------------------------------------------------------------
   // shifting
   // ---------------------------------------------------------------
   // msb leaves first; a fresh byte is taken at the first edge of a frame
   always @(posedge sck)
   begin
      if (nBits == 0)
         outSr = txByte;
      miso = outSr[7];
      outSr = {outSr[6:0], 1'h0};
   end
   // latch on the opposite edge; after the byte the line is inverted 2 ns later
   always @(negedge sck)
   begin
      rxByte = {rxByte[6:0], mosi};
      nBits = (nBits + 1) % 8;
      if (nBits == 0)
         miso <= #2 ~miso;
   end
   initial
   begin
      miso = 1'h0;
      rxByte = 8'h00;
   end
endmodule // ssp_slave_model
`default_nettype wire

// file: test_spi_serial_port_core.sv
// test_spi_serial_port_core: self-checking bench of the spi port core
// assumes: package, core, slave model and checker compiled before it
`default_nettype none
module test_spi_serial_port_core
   import ssp_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn = 1'h0, clkEn = 1'h1, tmrTick = 1'h0, miso, mSck;
   logic tbSck = 1'h0, tbMosi = 1'h0, ssN = 1'h1, slvMode = 1'h0;
   logic dirSdi = 1'h1, dirSdo = 1'h0, dirSck = 1'h0, dirSs = 1'h1;
   logic [4:0] wrs = 5'h00;
   logic [7:0] wrData = 8'h00, txByte = 8'h00, rxByte;
   logic sckOut, sckOen, sdoOut, sdoOen, irqFlag, pinsOwned;
   logic [7:0] ctlaRead, statRead, baudRead, bufRead;
   logic [3:0] modes [5] = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_BAUD,
      MODE_TMR};
   int halves [5] = '{2, 8, 32, 6, 0};
   int failures = 0, n_checks = 0, cyc = 0;
   // partner only sees a clean clock while the core drives it
   assign mSck = !sckOen && (sckOut === 1'h1);
   ssp_spi_core DUT (
      .clk(clk), .rstn(rstn), .clkEn(clkEn), .ctlaWr(wrs[0]),
      .statWr(wrs[1]), .baudWr(wrs[2]), .bufWr(wrs[3]), .wrData(wrData),
      .bufRd(wrs[4]), .tmrTick(tmrTick), .dirSdi(dirSdi), .dirSdo(dirSdo),
      .dirSck(dirSck), .dirSs(dirSs), .sckIn(sckOen ? tbSck : sckOut),
      .sckOut(sckOut), .sckOen(sckOen), .sdiIn(slvMode ? tbMosi : miso),
      .sdoOut(sdoOut), .sdoOen(sdoOen), .ssInN(ssN), .ctlaRead(ctlaRead),
      .statRead(statRead), .baudRead(baudRead), .bufRead(bufRead),
      .irqFlag(irqFlag), .pinsOwned(pinsOwned)
   );
   ssp_slave_model u_slv (
      .sck(mSck), .mosi(sdoOut), .miso(miso), .txByte(txByte),
      .rxByte(rxByte)
   );
   // ---------------------------------------------------------------
   // clock, timer event, hang guard
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      tmrTick <= (cyc % 3 == 0);
      if (cyc > 20000)
      begin
         failures++;
         results();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // strobe k: 0 ctl, 1 stat, 2 baud, 3 buffer write, 4 buffer read
   task automatic wr(input int k, input logic [7:0] d);
      @(posedge clk);
      wrs[k] <= 1'h1;
      wrData <= d;
      @(posedge clk);
      wrs <= 5'h00;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // bounded wait for byte done, counting clock-high samples
   task automatic waitIrq(output int hi);
      hi = 0;
      for (int i = 0; i < 1000 && irqFlag !== 1'h1; i++)
      begin
         tick(1);
         hi += (sckOut === 1'h1);
      end
      chk({7'h00, irqFlag}, 8'h01);
      tick(1);
   endtask
   task automatic results();
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial
   begin
      int hi;
      logic [7:0] got;
      repeat (8) @(posedge clk);
      rstn <= 1'h1;
      tick(2);
      chk(ctlaRead, CTLA_RST);
      chk(statRead, CTLS_RST);
      chk({6'h00, sckOen, sdoOen}, 8'h03);
      wr(1, 8'hc0);
      wr(1, 8'h00);
      wr(2, 8'h02);
      tick(2);
      chk(baudRead, 8'h02);
      // every master rate, each with a full exchange
      for (int i = 0; i < 5; i++)
      begin
         wr(0, {4'h0, modes[i]});
         wr(0, {4'h2, modes[i]});
         txByte = 8'h3c ^ 8'(i);
         wr(3, 8'ha5 ^ 8'(i));
         waitIrq(hi);
         chk(bufRead, 8'h3c ^ 8'(i));
         chk(rxByte, 8'ha5 ^ 8'(i));
         chk({7'h00, statRead[STAT_BF]}, 8'h01);
         if (i < 4)
            chk(8'(hi - 8 * halves[i]), 8'h00);
         wr(4, 8'h00);
         tick(2);
         chk({7'h00, statRead[STAT_BF]}, 8'h00);
      end
      // second write lands mid-transfer and must be dropped
      wr(0, 8'h00);
      wr(0, 8'h20);
      wr(3, 8'h11);
      wr(3, 8'h22);
      tick(2);
      chk(ctlaRead, 8'ha0);
      waitIrq(hi);
      chk(rxByte, 8'h11);
      wr(4, 8'h00);
      wr(0, 8'h20);
      dirSdo <= 1'h1;
      dirSck <= 1'h1;
      tick(3);
      chk({6'h00, sckOen, sdoOen}, 8'h03);
      chk(ctlaRead, 8'h20);
      dirSdo <= 1'h0;
      wr(0, 8'h00);
      // slave modes, bench plays the master
      slvMode <= 1'h1;
      for (int j = 0; j < 2; j++)
      begin
         wr(0, {4'h0, j ? MODE_SLV : MODE_SLV_SS});
         wr(0, {4'h2, j ? MODE_SLV : MODE_SLV_SS});
         wr(3, 8'h5a);
         tick(6);
         if (j == 0)
            chk({7'h00, sdoOen}, 8'h01);
         chk({7'h00, sckOen}, 8'h01);
         @(posedge clk);
         ssN <= 1'h0;
         tick(6);
         got = 8'h00;
         for (int b = 7; b >= 0; b--)
         begin
            @(posedge clk);
            tbSck <= 1'h1;
            tbMosi <= 1'(8'h96 >> b);
            tick(8);
            got = {got[6:0], sdoOut};
            @(posedge clk);
            tbSck <= 1'h0;
            tick(8);
         end
         waitIrq(hi);
         chk(bufRead, 8'h96);
         chk(got, 8'h5a);
         @(posedge clk);
         ssN <= 1'h1;
         tbMosi <= ~tbMosi;
         wr(4, 8'h00);
         wr(0, 8'h00);
      end
      tick(3);
      chk({7'h00, pinsOwned}, 8'h00);
      results();
   end
endmodule // test_spi_serial_port_core
`default_nettype wire
